// File: css_map.svh
// Purpose: constants of the compare trigger source selector
// Assumes: four compare channels, four capture channels, five timers
// Notes: codes not listed here are reserved and select nothing
// Operation
// - each compare channel keeps a five-bit source code; 00000 means no source.
// - code 11111 syncs the channel from its own secondary compare match.
// - codes 11110 and 11101 route external interrupt pins two and one.
// - codes 11011 down to 11000 route analog comparators four to one.
// - codes 10011 down to 10000 route capture interrupt events four to one.
// - codes 01111 down to 01011 route timers five to one.
// - after reset the code selects timer two (01100).
// - codes 01000 down to 00101 route capture events four to one.
// - codes 00100 down to 00001 route compare channels four to one; a channel's own code selects nothing.
// - switching a compare channel off emits a trigger-out pulse from it.
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
`define CSS_SEL_W 5
`define CSS_NUM_OC 4
`define CSS_NUM_IC 4
`define CSS_NUM_CMP 4
`define CSS_NUM_TMR 5
`define CSS_SEL_RESET 5'h0c
`define CSS_CODE_NONE 5'h00
`define CSS_CODE_OC1 5'h01
`define CSS_CODE_IC1_CAP 5'h05
`define CSS_CODE_TMR1 5'h0b
`define CSS_CODE_IC1_IRQ 5'h10
`define CSS_CODE_ANALOG_COMPARATOR_ONE 5'h18
`define CSS_CODE_EXT_IRQ_PIN_ONE 5'h1d
`define CSS_CODE_EXT_IRQ_PIN_TWO 5'h1e
`define CSS_CODE_OWN 5'h1f
`endif

// File: css_pkg.sv
// Purpose: types of the compare trigger source selector
// Assumes: css_map.svh holds the numbers
// Notes: none
`include "css_map.svh"
package css_pkg;
   typedef logic [`CSS_SEL_W-1:0] css_sel_t;
   typedef logic [(1<<`CSS_SEL_W)-1:0] css_evt_vec_t;
endpackage : css_pkg

// File: css_chan_if.sv
// Purpose: carrier between the selector top and one channel slice
// Assumes: css_pkg compiled first
// Notes: one instance per compare channel
`timescale 1ns/1ps
interface css_chan_if;
   css_pkg::css_evt_vec_t event_vec;
   logic sel_load;
   css_pkg::css_sel_t sel_value;
   css_pkg::css_sel_t sel_code;
   logic sync_trigger;
   modport top (output event_vec, output sel_load, output sel_value, input sel_code, input sync_trigger);
   modport chan (input event_vec, input sel_load, input sel_value, output sel_code, output sync_trigger);
endinterface : css_chan_if

// File: css_chan_sel.sv
// Purpose: source code register and event mux of one compare channel
// Assumes: event_vec is indexed by source code, reserved bits held low
// Notes: self code masked so a bad setting cannot loop a channel onto itself
`timescale 1ns/1ps
`include "css_map.svh"
module css_chan_sel #(
   parameter logic [`CSS_SEL_W-1:0] SELF_CODE = `CSS_CODE_OC1
) (
   input wire logic clock,
   input wire logic srst,
   css_chan_if.chan ch
);
   css_pkg::css_sel_t sel_reg;
   css_pkg::css_sel_t sel_next;
   logic trig_reg;
   logic trig_next;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      sel_next = sel_reg;
      if (ch.sel_load) begin
         sel_next = ch.sel_value;
      end
      trig_next = 1'b0;
      if (sel_reg == `CSS_CODE_NONE) begin
         trig_next = 1'b0;
      end else if (sel_reg == SELF_CODE) begin
         trig_next = 1'b0;
      end else begin
         trig_next = ch.event_vec[sel_reg];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         sel_reg <= `CSS_SEL_RESET;
         trig_reg <= 1'b0;
      end else begin
         sel_reg <= sel_next;
         trig_reg <= trig_next;
      end
   end

   assign ch.sel_code = sel_reg;
   assign ch.sync_trigger = trig_reg;
endmodule : css_chan_sel

// File: css_top.sv
// Purpose: trigger and sync source selection for four compare channels
// Assumes: timer, capture and compare events are one-cycle pulses on clock
// Notes: pins and comparator outputs are levels; their rising edge is the event
`timescale 1ns/1ps
`include "css_map.svh"
module css_top (
   input wire logic clock,
   input wire logic srst,
   input wire logic ext_irq_pin_one,
   input wire logic ext_irq_pin_two,
   input wire logic [`CSS_NUM_CMP-1:0] analog_comparator_out,
   input wire logic [`CSS_NUM_IC-1:0] capture_irq_event,
   input wire logic [`CSS_NUM_IC-1:0] capture_event,
   input wire logic [`CSS_NUM_TMR-1:0] timer_event,
   input wire logic [`CSS_NUM_OC-1:0] compare_match,
   input wire logic [`CSS_NUM_OC-1:0] secondary_compare_match,
   input wire logic [`CSS_NUM_OC-1:0] compare_enable,
   input wire logic [`CSS_NUM_OC-1:0] sel_load,
   input wire logic [`CSS_SEL_W-1:0] sel_value,
   output logic [`CSS_NUM_OC*`CSS_SEL_W-1:0] sync_source_select,
   output logic [`CSS_NUM_OC-1:0] trigger_out,
   output logic [`CSS_NUM_OC-1:0] sync_trigger
);
   localparam int NPIN = 2;

   // ext_irq_pin_one, ext_irq_pin_two; meta stage read only by the sync stage
   logic [NPIN-1:0] pin_meta_reg;
   logic [NPIN-1:0] pin_meta_next;
   logic [NPIN-1:0] pin_sync_reg;
   logic [NPIN-1:0] pin_sync_next;
   logic [NPIN-1:0] pin_prev_reg;
   logic [NPIN-1:0] pin_prev_next;
   logic [NPIN-1:0] pin_rise;

   // comparator levels are asynchronous too
   logic [`CSS_NUM_CMP-1:0] cmp_meta_reg;
   logic [`CSS_NUM_CMP-1:0] cmp_meta_next;
   logic [`CSS_NUM_CMP-1:0] cmp_sync_reg;
   logic [`CSS_NUM_CMP-1:0] cmp_sync_next;
   logic [`CSS_NUM_CMP-1:0] cmp_prev_reg;
   logic [`CSS_NUM_CMP-1:0] cmp_prev_next;
   logic [`CSS_NUM_CMP-1:0] cmp_rise;

   // per channel enable history and turn-off pulse
   logic en_one_reg;
   logic en_one_next;
   logic off_one_reg;
   logic off_one_next;
   logic en_two_reg;
   logic en_two_next;
   logic off_two_reg;
   logic off_two_next;
   logic en_three_reg;
   logic en_three_next;
   logic off_three_reg;
   logic off_three_next;
   logic en_four_reg;
   logic en_four_next;
   logic off_four_reg;
   logic off_four_next;

   // shared event vector, indexed by source code
   css_pkg::css_evt_vec_t base_vec;

   // one carrier per compare channel
   css_chan_if cif_one ();
   css_chan_if cif_two ();
   css_chan_if cif_three ();
   css_chan_if cif_four ();

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      pin_meta_next = {ext_irq_pin_two, ext_irq_pin_one};
      pin_sync_next = pin_meta_reg;
      pin_prev_next = pin_sync_reg;
      pin_rise = pin_sync_reg & ~pin_prev_reg;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end else begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
         pin_prev_reg <= pin_prev_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      cmp_meta_next = analog_comparator_out;
      cmp_sync_next = cmp_meta_reg;
      cmp_prev_next = cmp_sync_reg;
      cmp_rise = cmp_sync_reg & ~cmp_prev_reg;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cmp_meta_reg <= '0;
         cmp_sync_reg <= '0;
         cmp_prev_reg <= '0;
      end else begin
         cmp_meta_reg <= cmp_meta_next;
         cmp_sync_reg <= cmp_sync_next;
         cmp_prev_reg <= cmp_prev_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reserved codes and code zero stay low
   always_comb begin
      base_vec = '0;

      // a compare source fires on its match or on its turn-off pulse
      base_vec[`CSS_CODE_OC1 + 5'h00] = compare_match[0] | off_one_reg;
      base_vec[`CSS_CODE_OC1 + 5'h01] = compare_match[1] | off_two_reg;
      base_vec[`CSS_CODE_OC1 + 5'h02] = compare_match[2] | off_three_reg;
      base_vec[`CSS_CODE_OC1 + 5'h03] = compare_match[3] | off_four_reg;

      base_vec[`CSS_CODE_IC1_CAP + 5'h00] = capture_event[0];
      base_vec[`CSS_CODE_IC1_CAP + 5'h01] = capture_event[1];
      base_vec[`CSS_CODE_IC1_CAP + 5'h02] = capture_event[2];
      base_vec[`CSS_CODE_IC1_CAP + 5'h03] = capture_event[3];

      base_vec[`CSS_CODE_TMR1 + 5'h00] = timer_event[0];
      base_vec[`CSS_CODE_TMR1 + 5'h01] = timer_event[1];
      base_vec[`CSS_CODE_TMR1 + 5'h02] = timer_event[2];
      base_vec[`CSS_CODE_TMR1 + 5'h03] = timer_event[3];
      base_vec[`CSS_CODE_TMR1 + 5'h04] = timer_event[4];

      base_vec[`CSS_CODE_IC1_IRQ + 5'h00] = capture_irq_event[0];
      base_vec[`CSS_CODE_IC1_IRQ + 5'h01] = capture_irq_event[1];
      base_vec[`CSS_CODE_IC1_IRQ + 5'h02] = capture_irq_event[2];
      base_vec[`CSS_CODE_IC1_IRQ + 5'h03] = capture_irq_event[3];

      // rises only after the two-stage synchroniser, so two extra cycles
      base_vec[`CSS_CODE_ANALOG_COMPARATOR_ONE + 5'h00] = cmp_rise[0];
      base_vec[`CSS_CODE_ANALOG_COMPARATOR_ONE + 5'h01] = cmp_rise[1];
      base_vec[`CSS_CODE_ANALOG_COMPARATOR_ONE + 5'h02] = cmp_rise[2];
      base_vec[`CSS_CODE_ANALOG_COMPARATOR_ONE + 5'h03] = cmp_rise[3];
      base_vec[`CSS_CODE_EXT_IRQ_PIN_ONE] = pin_rise[0];
      base_vec[`CSS_CODE_EXT_IRQ_PIN_TWO] = pin_rise[1];
   end

   ////////////////////////////////////////////////////////////////////////
   // channel one
   always_comb begin
      en_one_next = compare_enable[0];
      // only a 1 to 0 step of the enable counts
      off_one_next = en_one_reg & ~compare_enable[0];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         en_one_reg <= 1'b0;
         off_one_reg <= 1'b0;
      end else begin
         en_one_reg <= en_one_next;
         off_one_reg <= off_one_next;
      end
   end

   // own secondary match rides on the top code
   always_comb begin
      cif_one.event_vec = base_vec;
      cif_one.event_vec[`CSS_CODE_OWN] = secondary_compare_match[0];
   end

   assign cif_one.sel_load = sel_load[0];
   assign cif_one.sel_value = sel_value;

   css_chan_sel #(
      .SELF_CODE(`CSS_CODE_OC1 + 5'h00)
   ) u_sel_one (
      .clock(clock),
      .srst(srst),
      .ch(cif_one.chan)
   );

   assign trigger_out[0] = off_one_reg;
   assign sync_source_select[`CSS_SEL_W*0 +: `CSS_SEL_W] = cif_one.sel_code;
   assign sync_trigger[0] = cif_one.sync_trigger;

   ////////////////////////////////////////////////////////////////////////
   // channel two
   always_comb begin
      en_two_next = compare_enable[1];
      // only a 1 to 0 step of the enable counts
      off_two_next = en_two_reg & ~compare_enable[1];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         en_two_reg <= 1'b0;
         off_two_reg <= 1'b0;
      end else begin
         en_two_reg <= en_two_next;
         off_two_reg <= off_two_next;
      end
   end

   // own secondary match rides on the top code
   always_comb begin
      cif_two.event_vec = base_vec;
      cif_two.event_vec[`CSS_CODE_OWN] = secondary_compare_match[1];
   end

   assign cif_two.sel_load = sel_load[1];
   assign cif_two.sel_value = sel_value;

   css_chan_sel #(
      .SELF_CODE(`CSS_CODE_OC1 + 5'h01)
   ) u_sel_two (
      .clock(clock),
      .srst(srst),
      .ch(cif_two.chan)
   );

   assign trigger_out[1] = off_two_reg;
   assign sync_source_select[`CSS_SEL_W*1 +: `CSS_SEL_W] = cif_two.sel_code;
   assign sync_trigger[1] = cif_two.sync_trigger;

   ////////////////////////////////////////////////////////////////////////
   // channel three
   always_comb begin
      en_three_next = compare_enable[2];
      // only a 1 to 0 step of the enable counts
      off_three_next = en_three_reg & ~compare_enable[2];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         en_three_reg <= 1'b0;
         off_three_reg <= 1'b0;
      end else begin
         en_three_reg <= en_three_next;
         off_three_reg <= off_three_next;
      end
   end

   // own secondary match rides on the top code
   always_comb begin
      cif_three.event_vec = base_vec;
      cif_three.event_vec[`CSS_CODE_OWN] = secondary_compare_match[2];
   end

   assign cif_three.sel_load = sel_load[2];
   assign cif_three.sel_value = sel_value;

   css_chan_sel #(
      .SELF_CODE(`CSS_CODE_OC1 + 5'h02)
   ) u_sel_three (
      .clock(clock),
      .srst(srst),
      .ch(cif_three.chan)
   );

   assign trigger_out[2] = off_three_reg;
   assign sync_source_select[`CSS_SEL_W*2 +: `CSS_SEL_W] = cif_three.sel_code;
   assign sync_trigger[2] = cif_three.sync_trigger;

   ////////////////////////////////////////////////////////////////////////
   // channel four
   always_comb begin
      en_four_next = compare_enable[3];
      // only a 1 to 0 step of the enable counts
      off_four_next = en_four_reg & ~compare_enable[3];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         en_four_reg <= 1'b0;
         off_four_reg <= 1'b0;
      end else begin
         en_four_reg <= en_four_next;
         off_four_reg <= off_four_next;
      end
   end

   // own secondary match rides on the top code
   always_comb begin
      cif_four.event_vec = base_vec;
      cif_four.event_vec[`CSS_CODE_OWN] = secondary_compare_match[3];
   end

   assign cif_four.sel_load = sel_load[3];
   assign cif_four.sel_value = sel_value;

   css_chan_sel #(
      .SELF_CODE(`CSS_CODE_OC1 + 5'h03)
   ) u_sel_four (
      .clock(clock),
      .srst(srst),
      .ch(cif_four.chan)
   );

   assign trigger_out[3] = off_four_reg;
   assign sync_source_select[`CSS_SEL_W*3 +: `CSS_SEL_W] = cif_four.sel_code;
   assign sync_trigger[3] = cif_four.sync_trigger;

endmodule : css_top

// File: css_top_asserts.sv
// Purpose: port checker for css_top
// Assumes: one clock, srst sync high
// Notes: channel one watched closely, others sampled
`timescale 1ns/1ps
module css_top_asserts (
   input wire logic clock,
   input wire logic srst,
   input wire logic ext_irq_pin_one,
   input wire logic ext_irq_pin_two,
   input wire logic [3:0] analog_comparator_out,
   input wire logic [3:0] capture_irq_event,
   input wire logic [3:0] capture_event,
   input wire logic [4:0] timer_event,
   input wire logic [3:0] compare_match,
   input wire logic [3:0] secondary_compare_match,
   input wire logic [3:0] compare_enable,
   input wire logic [3:0] sel_load,
   input wire logic [4:0] sel_value,
   input wire logic [19:0] sync_source_select,
   input wire logic [3:0] trigger_out,
   input wire logic [3:0] sync_trigger
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   a_reset_sel: assert property (disable iff (1'b0) srst |=> sync_source_select == {4{5'h0c}}) else $error("rst");
   a_load_takes: assert property (sel_load[3] |=> sync_source_select[19:15] == $past(sel_value)) else $error("ld");
   a_timer_sync: assert property (timer_event[1] && sync_source_select[4:0] == 5'h0c |=> sync_trigger[0]) else $error("tm");
   a_none_quiet: assert property (sync_source_select[4:0] == 5'h00 |=> !sync_trigger[0]) else $error("none");
   a_own_masked: assert property (sync_source_select[4:0] == 5'h01 |=> !sync_trigger[0]) else $error("own");
   a_rsvd_quiet: assert property (sync_source_select[4:0] inside {5'h1c, 5'h09, 5'h0a, [5'h14:5'h17]}
      |=> !sync_trigger[0]) else $error("rsvd");
   a_off_pulse: assert property ($fell(compare_enable[2]) |=> trigger_out[2] ##1 !trigger_out[2]) else $error("off");
   a_pin_delay: assert property ($rose(ext_irq_pin_one) ##2 sync_source_select[4:0] == 5'h1d
      |=> sync_trigger[0]) else $error("pin");
   cover property (timer_event[1] && sync_source_select[4:0] == 5'h0c);
   cover property ($fell(compare_enable[2]));
   cover property ($rose(ext_irq_pin_one) ##2 sync_source_select[4:0] == 5'h1d);
endmodule : css_top_asserts
bind css_top css_top_asserts i_css_top_asserts (.*);

// File: compare_trigger_source_select_bench.sv
// Purpose: random self-check of css_top
// Assumes: pins and comparators share one two-step rise pipe
// Notes: only unselected channels are switched off
`timescale 1ns/1ps
module compare_trigger_source_select_bench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [5:0] lv = 6'h00;
   logic [3:0] cirq = 4'h0, cap = 4'h0, cm = 4'h0, sec = 4'h0, en = 4'h0, ld = 4'h0, offp = 4'h0;
   logic [4:0] tmr = 5'h00, val = 5'h00;
   logic [19:0] sss;
   logic [3:0] tro, syt;
   logic [4:0] sel [4];
   logic [5:0] d [2];
   logic [27:0] q [$];
   int bad_count = 0;
   int comparisons = 0;
   always #2.5 clock = ~clock;
   css_top i_css_top (.clock(clock), .srst(srst), .ext_irq_pin_one(lv[0]), .ext_irq_pin_two(lv[1]),
      .analog_comparator_out(lv[5:2]), .capture_irq_event(cirq), .capture_event(cap), .timer_event(tmr),
      .compare_match(cm), .secondary_compare_match(sec), .compare_enable(en), .sel_load(ld),
      .sel_value(val), .sync_source_select(sss), .trigger_out(tro), .sync_trigger(syt));
   function automatic logic [5:0] sp();
      return 6'($urandom & $urandom & $urandom);
   endfunction : sp
   function automatic logic hit(input logic [4:0] c, input int g);
      case (c) inside
         5'h1f: return sec[g];
         5'h1d, 5'h1e: return d[1][c - 5'h1d];
         [5'h18:5'h1b]: return d[1][c - 5'h16];
         [5'h10:5'h13]: return cirq[c - 5'h10];
         [5'h0b:5'h0f]: return tmr[c - 5'h0b];
         [5'h05:5'h08]: return cap[c - 5'h05];
         [5'h01:5'h04]: return (5'(g) != c - 5'h01) && (cm[c - 5'h01] | offp[c - 5'h01]);
         default: return 1'b0;
      endcase
   endfunction : hit
   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   always @(posedge clock) begin
      #1;
      if (q.size() > 0) check({sss, tro, syt}, q.pop_front());
   end
   initial begin
      #20000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      logic [3:0] t, nen;
      logic [5:0] nl;
      void'($urandom(28639));
      d = '{default: 6'h00};
      sel = '{default: 5'h0c};
      repeat (5) @(negedge clock);
      srst = 1'b0;
      check({sss, tro, syt}, {{4{5'h0c}}, 8'h00});
      repeat (3000) begin
         {cirq, cap, cm, sec} = 16'({sp(), sp(), sp()});
         tmr = 5'(sp());
         ld = 4'($urandom & $urandom);
         val = 5'($urandom);
         for (int g = 0; g < 4; g++) begin
            t[g] = hit(sel[g], g);
            if (ld[g]) sel[g] = val;
         end
         // a selected source is never switched off
         nen = en ^ 4'(sp());
         for (int i = 0; i < 4; i++)
            for (int g = 0; g < 4; g++) if (sel[g] == 5'(i + 1)) nen[i] = en[i];
         q.push_back({sel[3], sel[2], sel[1], sel[0], en & ~nen, t});
         offp = en & ~nen;
         en = nen;
         nl = lv ^ sp();
         d[1] = d[0];
         d[0] = nl & ~lv;
         lv = nl;
         @(negedge clock);
      end
      report_and_stop();
   end
endmodule : compare_trigger_source_select_bench
